// ### verilog/usbep_pkg.sv
// Constants, types and mode functions for the endpoint and pin block
package usbep_pkg;
   // ---------------------------------------------------------------
   // Register indices and byte addresses (byte address = 4 * index)
   // ---------------------------------------------------------------
   localparam logic [7:0] IDX_PORT2 = 8'h02;
   localparam logic [7:0] IDX_ADDR  = 8'h10;
   localparam logic [7:0] IDX_CNT0  = 8'h11;
   localparam logic [7:0] IDX_CNT1  = 8'h13;
   localparam logic [7:0] IDX_MODE1 = 8'h14;
   localparam logic [7:0] IDX_CTRL  = 8'h1F;
   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int TOG_B   = 7;
   localparam int VAL_B   = 6;
   localparam int STALL_B = 7;
   localparam int ACKF_B  = 4;
   localparam int AEN_B   = 7;
   localparam int PU_B    = 7;
   localparam int VHIZ_B  = 6;
   localparam int REGON_B = 3;
   localparam int DP_B    = 5;
   localparam int DM_B    = 4;
   localparam int VRIN_B  = 0;
   localparam logic [7:0] REG_RST   = 8'h00;
   localparam logic [3:0] CRC_BYTES = 4'h2;
   localparam logic [1:0] RESP_OK   = 2'h0;
   localparam logic [1:0] RESP_ERR  = 2'h2;
   // ---------------------------------------------------------------
   // Pin forcing codes and endpoint modes
   // ---------------------------------------------------------------
   localparam logic [2:0] FRC_SIE  = 3'h0;
   localparam logic [2:0] FRC_K    = 3'h1;
   localparam logic [2:0] FRC_J    = 3'h2;
   localparam logic [2:0] FRC_SE0  = 3'h3;
   localparam logic [2:0] FRC_LL   = 3'h4;
   localparam logic [2:0] FRC_DMLO = 3'h5;
   localparam logic [2:0] FRC_DPLO = 3'h6;
   localparam logic [2:0] FRC_HIZ  = 3'h7;
   localparam logic [3:0] M_DIS    = 4'h0;
   localparam logic [3:0] M_NAK    = 4'h1;
   localparam logic [3:0] M_AOUT   = 4'hB;
   localparam logic [3:0] M_AIN    = 4'hF;
   // Long low on the data line: 128 us at 20 MHz
   localparam int PS2_LOW_US = 128;
   localparam int CLK_MHZ    = 20;
   localparam logic [11:0] PS2_LOW_CYC = 12'(PS2_LOW_US * CLK_MHZ);
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      TK_OUT   = 2'h0,
      TK_IN    = 2'h1,
      TK_SETUP = 2'h2,
      TK_NONE  = 2'h3
   } usbep_tok_t;
   typedef enum logic [1:0] {
      RS_IGN   = 2'h0,
      RS_ACK   = 2'h1,
      RS_NAK   = 2'h2,
      RS_STALL = 2'h3
   } usbep_resp_t;
   // One-cycle report from the engine at the end of a transaction
   typedef struct packed {
      logic       done;
      usbep_tok_t tok;
      logic       ep;
      logic       acked;
      logic       err;
      logic       tog;
      logic [3:0] nbytes;
   } usbep_evt_t;
   // Handshake answer for a token, used for the second endpoint only
   function automatic usbep_resp_t mode_resp(
      input logic [3:0] md, input logic stall, input usbep_tok_t tk);
      usbep_resp_t r;
      r = RS_NAK;
      if (tk == TK_NONE || md == M_DIS)
         r = RS_IGN;
      else if (tk == TK_SETUP)
         r = RS_ACK;
      else if (md == M_AOUT && tk == TK_OUT)
         r = stall ? RS_STALL : RS_ACK;
      else if (md == M_AIN && tk == TK_IN)
         r = stall ? RS_STALL : RS_ACK;
      return r;
   endfunction
   // Automatic mode change after an acknowledged transaction
   function automatic logic [3:0] mode_next(
      input logic [3:0] md, input usbep_tok_t tk, input logic ack);
      logic [3:0] n;
      n = md;
      if (ack && (tk == TK_SETUP ||
          (md == M_AOUT && tk == TK_OUT) ||
          (md == M_AIN && tk == TK_IN)))
         n = M_NAK;
      return n;
   endfunction
endpackage

// ### verilog/usbep_core.sv
// Endpoint status, counters, register slave and D+/D-/regulator pins
//
// Summary of operation
// R1: Stall OUT/IN when stall set in ACK mode
// R2: Firmware clears stall outside ACK modes
// R3: Firmware writes zeros to reserved mode bits
// R4: Ack flag follows whether transaction was acked
// R5: Second endpoint modes behave like control endpoint
// R6: Two counter registers with identical layout
// R7: Toggle chosen by firmware, captured on OUT/SETUP
// R8: Valid bit cleared on error, set otherwise
// R9: Endpoint event raised even for invalid data
// R10: Firmware loads IN count zero to eight
// R11: Received count is data bytes plus two
// R12: Control count locks on update, read unlocks
// R13: Regulator pin high impedance until enabled
// R14: Regulator pin readable at port two bit zero
// R15: Suspend stops regulator, weak pull-up if enabled
// R16: Address enable also turns regulator on
// R17: Regulator released while engine transmits
// R18: D+/D- double as PS/2 lines
// R19: Long data-line low raises PS/2 event
// R20: Pin levels readable, lines pulled low singly
// R21: Control bit seven enables PS/2 pull-ups
// R22: Control bit six floats the regulator pin
// R23: Forcing codes, 111 first arms PS/2 codes
// R24: Engine answers only while address enabled
// R25: Acked ACK-OUT falls back to NAK mode
// R26: Reserved bits read zero, writes ignored
`timescale 1ns/1ns
module usbep_core (
   input  wire logic               mclk,
   input  wire logic               nrst,
   input  wire logic [7:0]         awaddr,
   input  wire logic               awvalid,
   output      logic               awready,
   input  wire logic [31:0]        wdata,
   input  wire logic [3:0]         wstrb,
   input  wire logic               wvalid,
   output      logic               wready,
   output      logic [1:0]         bresp,
   output      logic               bvalid,
   input  wire logic               bready,
   input  wire logic [7:0]         araddr,
   input  wire logic               arvalid,
   output      logic               arready,
   output      logic [31:0]        rdata,
   output      logic [1:0]         rresp,
   output      logic               rvalid,
   input  wire logic               rready,
   input  wire usbep_pkg::usbep_evt_t sie_evt,
   input  wire usbep_pkg::usbep_tok_t sie_tok,
   output usbep_pkg::usbep_resp_t     ep1_resp,
   input  wire logic               sie_tx,
   input  wire logic               sie_dp,
   input  wire logic               sie_dm,
   input  wire logic               usb_bus_rst,
   input  wire logic               suspend,
   output      logic [7:0]         ep0_cnt,
   output      logic [7:0]         ep1_cnt,
   output      logic               addr_en,
   output      logic [6:0]         dev_addr,
   input  wire logic               dp_i,
   output      logic               dp_o,
   output      logic               dp_oe,
   input  wire logic               dm_i,
   output      logic               dm_o,
   output      logic               dm_oe,
   input  wire logic               pullup_regulator_output_i,
   output      logic               pullup_regulator_output_o,
   output      logic               pullup_regulator_output_oe,
   output      logic               pullup_regulator_output_weak_pu,
   output      logic               ps2_pu_en,
   output      logic [1:0]         ep_irq,
   output      logic               ps2_irq
);
   // Every assertion below runs on mclk and rests during reset
   default clocking cb_chk @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [7:0]  addr_r;
   logic [7:0]  cnt0_r;
   logic [7:0]  cnt1_r;
   logic        lock0_r;
   logic        stall_r;
   logic        ackf_r;
   logic [3:0]  mode1_r;
   logic [7:0]  ctrl_r;
   logic        armed_r;
   logic [7:0]  aw_r;
   logic        aw_full_r;
   logic [7:0]  wd_r;
   logic        wl_r;
   logic        w_full_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;
   logic [1:0]  irq_r;
   logic [11:0] low_cnt_r;
   logic        ps2_irq_r;
   logic        wr_go;
   logic        rd_go;
   logic        hw_rx;
   logic        hw0;
   logic        hw1;
   logic [7:0]  rx_cnt;
   logic [7:0]  rd_val;
   logic        rd_ok;
   logic        wr_ok;
   logic        reg_act;

   // Match a byte address against a register index
   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] idx);
      return a[7:2] == idx[5:0];
   endfunction

   // Write selects; a write without the low lane changes nothing
   function automatic logic wsel(input logic [7:0] idx);
      return wr_go && wl_r && hit(aw_r, idx);
   endfunction

   // ---------------------------------------------------------------
   // AXI4-Lite write channel
   // ---------------------------------------------------------------
   assign awready = !aw_full_r && !bvalid_r;
   assign wready  = !w_full_r && !bvalid_r;
   assign wr_go   = aw_full_r && w_full_r && !bvalid_r;
   assign bvalid  = bvalid_r;
   assign bresp   = bresp_r;

   // Address and data may arrive in either order
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         aw_r      <= usbep_pkg::REG_RST;
         aw_full_r <= 1'b0;
         wd_r      <= usbep_pkg::REG_RST;
         wl_r      <= 1'b0;
         w_full_r  <= 1'b0;
      end else begin
         if (awvalid && awready) begin
            aw_r      <= awaddr;
            aw_full_r <= 1'b1;
         end else if (wr_go) begin
            aw_full_r <= 1'b0;
         end
         if (wvalid && wready) begin
            wd_r     <= wdata[7:0];
            wl_r     <= wstrb[0];
            w_full_r <= 1'b1;
         end else if (wr_go) begin
            w_full_r <= 1'b0;
         end
      end
   end

   // Decode check for writes; port two is read-only
   always_comb begin
      wr_ok = hit(aw_r, usbep_pkg::IDX_ADDR)
           || hit(aw_r, usbep_pkg::IDX_CNT0)
           || hit(aw_r, usbep_pkg::IDX_CNT1)
           || hit(aw_r, usbep_pkg::IDX_MODE1)
           || hit(aw_r, usbep_pkg::IDX_CTRL);
   end

   // Write response; unmapped addresses answer SLVERR
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         bvalid_r <= 1'b0;
         bresp_r  <= usbep_pkg::RESP_OK;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r  <= wr_ok ? usbep_pkg::RESP_OK : usbep_pkg::RESP_ERR;
      end else if (bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite read channel
   // ---------------------------------------------------------------
   assign arready = !rvalid_r;
   assign rd_go   = arvalid && arready;
   assign rvalid  = rvalid_r;
   assign rdata   = rdata_r;
   assign rresp   = rresp_r;

   // Read mux; reserved bits read zero (see R26)
   always_comb begin
      rd_val = 8'h00;
      rd_ok  = 1'b1;
      if (hit(araddr, usbep_pkg::IDX_ADDR))
         rd_val = addr_r;
      else if (hit(araddr, usbep_pkg::IDX_CNT0))
         rd_val = cnt0_r;
      else if (hit(araddr, usbep_pkg::IDX_CNT1))
         rd_val = cnt1_r;
      else if (hit(araddr, usbep_pkg::IDX_MODE1)) begin
         rd_val[usbep_pkg::STALL_B] = stall_r;
         rd_val[usbep_pkg::ACKF_B]  = ackf_r;
         rd_val[3:0]                = mode1_r;
      end else if (hit(araddr, usbep_pkg::IDX_CTRL))
         rd_val = ctrl_r;
      else if (hit(araddr, usbep_pkg::IDX_PORT2)) begin
         rd_val[usbep_pkg::DP_B]   = dp_i;   // see R20
         rd_val[usbep_pkg::DM_B]   = dm_i;   // see R20
         rd_val[usbep_pkg::VRIN_B] = pullup_regulator_output_i; // see R14
      end else
         rd_ok = 1'b0;
   end

   // Read data is captured at the address handshake
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= usbep_pkg::RESP_OK;
      end else if (rd_go) begin
         rvalid_r <= 1'b1;
         rdata_r  <= {24'h00_0000, rd_val};
         rresp_r  <= rd_ok ? usbep_pkg::RESP_OK : usbep_pkg::RESP_ERR;
      end else if (rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Engine reports
   // ---------------------------------------------------------------
   assign hw_rx  = sie_evt.done && (sie_evt.tok == usbep_pkg::TK_OUT
                || sie_evt.tok == usbep_pkg::TK_SETUP);
   assign hw0    = hw_rx && !sie_evt.ep;
   assign hw1    = hw_rx && sie_evt.ep;
   // Received count carries the two CRC bytes (see R11)
   assign rx_cnt = {sie_evt.tog, !sie_evt.err, 2'b00,
                    4'(sie_evt.nbytes + usbep_pkg::CRC_BYTES)};

   // Counter registers share one layout (see R6)
   // Hardware update wins over a same-cycle CPU write (see R7, R8)
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt0_r <= usbep_pkg::REG_RST;
         cnt1_r <= usbep_pkg::REG_RST;
      end else begin
         if (hw0)
            cnt0_r <= rx_cnt;
         else if (wsel(usbep_pkg::IDX_CNT0) && !lock0_r) // see R12
            cnt0_r <= wd_r & 8'hCF;                        // see R26
         if (hw1)
            cnt1_r <= rx_cnt;
         else if (wsel(usbep_pkg::IDX_CNT1))
            cnt1_r <= wd_r & 8'hCF;                        // see R26
      end
   end
   assign ep0_cnt = cnt0_r;
   assign ep1_cnt = cnt1_r;

   // Lock set by an update, cleared by a read; set wins (see R12)
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         lock0_r <= 1'b0;
      else if (hw0)
         lock0_r <= 1'b1;
      else if (rd_go && hit(araddr, usbep_pkg::IDX_CNT0))
         lock0_r <= 1'b0;
   end

   // Second endpoint mode register; engine outranks firmware
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         stall_r <= 1'b0;
         ackf_r  <= 1'b0;
         mode1_r <= usbep_pkg::M_DIS;
      end else if (sie_evt.done && sie_evt.ep) begin
         ackf_r  <= sie_evt.acked;                         // see R4
         mode1_r <= usbep_pkg::mode_next(mode1_r,          // see R5
                       sie_evt.tok, sie_evt.acked);        // see R25
      end else if (wsel(usbep_pkg::IDX_MODE1)) begin
         stall_r <= wd_r[usbep_pkg::STALL_B];
         ackf_r  <= wd_r[usbep_pkg::ACKF_B];
         mode1_r <= wd_r[3:0];
      end
   end

   // Handshake answer, silent while the address is off
   always_comb begin
      ep1_resp = usbep_pkg::RS_IGN;
      if (addr_en)                                          // see R24
         ep1_resp = usbep_pkg::mode_resp(mode1_r, stall_r,  // see R1
                                         sie_tok);
   end

   // Endpoint event pulse even for invalid data (see R9)
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         irq_r <= 2'b00;
      else
         irq_r <= {sie_evt.done && sie_evt.ep,
                   sie_evt.done && !sie_evt.ep};
   end
   assign ep_irq = irq_r;

   // ---------------------------------------------------------------
   // Address and control registers
   // ---------------------------------------------------------------
   // Bus reset clears the address like a hardware reset
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         addr_r <= usbep_pkg::REG_RST;
      else if (usb_bus_rst)
         addr_r <= usbep_pkg::REG_RST;
      else if (wsel(usbep_pkg::IDX_ADDR))
         addr_r <= wd_r;
   end
   assign addr_en  = addr_r[usbep_pkg::AEN_B];
   assign dev_addr = addr_r[6:0];

   // Pull-ups, regulator float, regulator on, forcing code
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         ctrl_r <= usbep_pkg::REG_RST;
      else if (wsel(usbep_pkg::IDX_CTRL))
         ctrl_r <= wd_r & 8'hCF;
   end
   assign ps2_pu_en = ctrl_r[usbep_pkg::PU_B]; // see R21

   // PS/2 drive codes stay inert until 111 has been seen (see R23)
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         armed_r <= 1'b0;
      else if (ctrl_r[2:0] == usbep_pkg::FRC_HIZ)
         armed_r <= 1'b1;
   end

   // ---------------------------------------------------------------
   // D+/D- drivers
   // ---------------------------------------------------------------
   // PS/2 codes only pull low, open drain (see R18, R20, R23)
   always_comb begin
      dp_o  = 1'b0;
      dm_o  = 1'b0;
      dp_oe = 1'b0;
      dm_oe = 1'b0;
      unique case (ctrl_r[2:0])
         usbep_pkg::FRC_SIE: begin
            dp_o  = sie_dp;
            dm_o  = sie_dm;
            dp_oe = sie_tx && addr_en;
            dm_oe = sie_tx && addr_en;
         end
         usbep_pkg::FRC_K: begin
            dp_o  = 1'b1;
            dp_oe = 1'b1;
            dm_oe = 1'b1;
         end
         usbep_pkg::FRC_J: begin
            dm_o  = 1'b1;
            dp_oe = 1'b1;
            dm_oe = 1'b1;
         end
         usbep_pkg::FRC_SE0: begin
            dp_oe = 1'b1;
            dm_oe = 1'b1;
         end
         usbep_pkg::FRC_LL: begin
            dp_oe = armed_r;
            dm_oe = armed_r;
         end
         usbep_pkg::FRC_DMLO: dm_oe = armed_r;
         usbep_pkg::FRC_DPLO: dp_oe = armed_r;
         usbep_pkg::FRC_HIZ: begin
            dp_oe = 1'b0;
            dm_oe = 1'b0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Regulator pin
   // ---------------------------------------------------------------
   // Float wins over both enables of the driver; the suspend weak pull-up ignores it
   assign reg_act = (ctrl_r[usbep_pkg::REGON_B] || addr_en)  // see R16
                 && !ctrl_r[usbep_pkg::VHIZ_B]                // see R22
                 && !suspend;                                 // see R15
   assign pullup_regulator_output_o       = 1'b1;
   assign pullup_regulator_output_oe      = reg_act && !sie_tx;                  // see R13, R17
   assign pullup_regulator_output_weak_pu = suspend && ctrl_r[usbep_pkg::REGON_B]; // see R15

   // ---------------------------------------------------------------
   // PS/2 activity detector
   // ---------------------------------------------------------------
   // Counts low cycles on the data line; one pulse per low period
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         low_cnt_r <= 12'h000;
         ps2_irq_r <= 1'b0;
      end else begin
         ps2_irq_r <= 1'b0;
         if (dm_i)
            low_cnt_r <= 12'h000;
         else if (low_cnt_r != usbep_pkg::PS2_LOW_CYC) begin
            low_cnt_r <= low_cnt_r + 12'h001;
            ps2_irq_r <= (low_cnt_r == usbep_pkg::PS2_LOW_CYC
                          - 12'h001);                       // see R19
         end
      end
   end
   assign ps2_irq = ps2_irq_r;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   sequence s_ep1_rx_ok;
      sie_evt.done && sie_evt.ep && !sie_evt.err &&
      sie_evt.tok == usbep_pkg::TK_OUT;
   endsequence
   sequence s_locked_write;
      lock0_r && wr_go && wl_r && hit(aw_r, usbep_pkg::IDX_CNT0)
      && !hw0;
   endsequence

   chk_stall_out: assert property ( // see R1
      addr_en && stall_r && mode1_r == usbep_pkg::M_AOUT &&
      sie_tok == usbep_pkg::TK_OUT |-> ep1_resp == usbep_pkg::RS_STALL)
      else $error("stall not given for OUT");
   chk_ack_flag: assert property ( // see R4
      sie_evt.done && sie_evt.ep |=> ackf_r == $past(sie_evt.acked))
      else $error("ack flag wrong");
   chk_mode_fall: assert property ( // see R25
      s_ep1_rx_ok ##0 sie_evt.acked && mode1_r == usbep_pkg::M_AOUT
      |=> mode1_r == usbep_pkg::M_NAK)
      else $error("mode did not fall back");
   chk_toggle_copy: assert property ( // see R7
      s_ep1_rx_ok |=> cnt1_r[usbep_pkg::TOG_B] == $past(sie_evt.tog)
      && cnt1_r[usbep_pkg::VAL_B])
      else $error("toggle not captured");
   chk_valid_err: assert property ( // see R8
      hw_rx && sie_evt.err |=> ($past(sie_evt.ep) ?
      !ep1_cnt[usbep_pkg::VAL_B] : !ep0_cnt[usbep_pkg::VAL_B]))
      else $error("valid not cleared");
   chk_irq_err: assert property ( // see R9
      sie_evt.done && sie_evt.err |=> ep_irq != 2'b00)
      else $error("endpoint event lost");
   chk_count_plus: assert property ( // see R11
      hw1 |=> cnt1_r[3:0] == $past(sie_evt.nbytes) + usbep_pkg::CRC_BYTES)
      else $error("count not plus two");
   chk_lock_hold: assert property ( // see R12
      s_locked_write |=> $stable(cnt0_r) ##1 lock0_r || rvalid)
      else $error("locked count overwritten");
   chk_reg_off: assert property ( // see R13
      !ctrl_r[usbep_pkg::REGON_B] && !addr_en |-> !pullup_regulator_output_oe)
      else $error("regulator driven while off");
   chk_susp_pu: assert property ( // see R15
      suspend |-> !pullup_regulator_output_oe && pullup_regulator_output_weak_pu == ctrl_r[usbep_pkg::REGON_B])
      else $error("suspend regulator wrong");
   chk_ps2_event: assert property ( // see R19
      ps2_irq |-> !$past(dm_i) &&
      low_cnt_r == usbep_pkg::PS2_LOW_CYC)
      else $error("PS/2 event without long low");
endmodule

// ### verification/usbep_host_model.sv
// Far-side model: pull-ups and a PS/2 host on the shared lines
`timescale 1ns/1ns
module usbep_host_model (
   input  wire logic dp_o,
   input  wire logic dp_oe,
   input  wire logic dm_o,
   input  wire logic dm_oe,
   input  wire logic pullup_regulator_output_o,
   input  wire logic pullup_regulator_output_oe,
   input  wire logic hold_low,
   output wire logic dp_i,
   output wire logic dm_i,
   output wire logic pullup_regulator_output_i
);
   // -----------------------------------------------
   // Wire levels
   // -----------------------------------------------
   // Released lines float high through pull-ups
   assign dp_i = dp_oe ? dp_o : 1'b1;
   // Host may clamp the data line low, as in PS/2 traffic
   assign dm_i = (dm_oe ? dm_o : 1'b1) & ~hold_low;
   // External supply keeps the pin high when released
   assign pullup_regulator_output_i = pullup_regulator_output_oe ? pullup_regulator_output_o : 1'b1;
endmodule

// ### verification/tb_usbep_core.sv
// Testbench for the endpoint status and pin control block
`timescale 1ns/1ns
module tb_usbep_core;
   // -----------------------------------------------
   // Signals
   // -----------------------------------------------
   logic                   mclk, nrst, awvalid, wvalid, bready, arvalid;
   logic                   rready, sie_tx, suspend, hold_low, ps2_irq;
   logic                   awready, wready, bvalid, arready, rvalid;
   logic                   addr_en, dp_i, dp_o, dp_oe, dm_i, dm_o, dm_oe;
   logic                   pullup_regulator_output_i, pullup_regulator_output_o, pullup_regulator_output_oe, pullup_regulator_output_weak_pu, ps2_pu_en;
   logic [7:0]             awaddr, araddr, ep0_cnt, ep1_cnt, rd_v;
   logic [31:0]            wdata, rdata;
   logic [1:0]             bresp, rresp, ep_irq, rsp;
   logic [6:0]             dev_addr;
   logic [16:0]            rows [4];
   usbep_pkg::usbep_evt_t  sie_evt;
   usbep_pkg::usbep_tok_t  sie_tok;
   usbep_pkg::usbep_resp_t ep1_resp;
   int                     n_mismatch = 0, checks_done = 0, cyc = 0, i;
   localparam logic [7:0]  A_C0 = usbep_pkg::IDX_CNT0 << 2;
   localparam logic [7:0]  A_C1 = usbep_pkg::IDX_CNT1 << 2;
   localparam logic [7:0]  A_M1 = usbep_pkg::IDX_MODE1 << 2;
   localparam logic [7:0]  A_CT = usbep_pkg::IDX_CTRL << 2;
   localparam logic [7:0]  A_AD = usbep_pkg::IDX_ADDR << 2;
   localparam logic [7:0]  A_P2 = usbep_pkg::IDX_PORT2 << 2;

   usbep_core u_usbep_core (.wstrb(4'hF), .sie_dp(1'b0), .sie_dm(1'b0),
      .usb_bus_rst(1'b0), .*);
   usbep_host_model u_usbep_host_model (.*);

   // Clock and hang guard; a stuck handshake ends as a failure
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end

   // -----------------------------------------------
   // Tasks
   // -----------------------------------------------
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      checks_done++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // Ready is sampled mid-cycle, since it is combinational
   task automatic wr(input logic [7:0] a, d, output logic [1:0] r);
      logic ra, rw, b;
      @(posedge mclk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      {awvalid, wvalid, bready} <= 3'h7;
      do begin
         @(negedge mclk);
         {ra, rw, b, r} = {awready, wready, bvalid, bresp};
         @(posedge mclk);
         if (ra) awvalid <= 1'b0;
         if (rw) wvalid <= 1'b0;
      end while (!b);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic [1:0] r);
      logic ar, v;
      @(posedge mclk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do begin
         @(negedge mclk);
         {ar, v, d, r} = {arready, rvalid, rdata[7:0], rresp};
         @(posedge mclk);
         if (ar) arvalid <= 1'b0;
      end while (!v);
      rready <= 1'b0;
   endtask
   // Engine report {ep, tok, err, tog, nbytes}; ack unless error
   task automatic ev(input logic [8:0] e);
      @(posedge mclk);
      sie_evt <= {1'b1, e[7:6], e[8], ~e[5], e[5:0]};
      @(posedge mclk);
      sie_evt.done <= 1'b0;
      @(negedge mclk);
      chk(ep_irq, e[8] ? 8'h02 : 8'h01);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // -----------------------------------------------
   // Main sequence
   // -----------------------------------------------
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {sie_tx, suspend, hold_low, nrst} = 4'h0;
      {awaddr, araddr, wdata} = 48'h0;
      sie_evt = '0;
      sie_tok = usbep_pkg::TK_NONE;
      rows = '{17'h113C5, 17'h1A80A, 17'h1550A, 17'h00042};
      repeat (5) @(posedge mclk);
      nrst <= 1'b1;
      rd(A_C1, rd_v, rsp);
      chk(rd_v, usbep_pkg::REG_RST);
      chk(pullup_regulator_output_oe, 8'h00);
      $display("reset test done");
      for (i = 0; i < 4; i++) begin
         ev(rows[i][16:8]);
         rd(rows[i][16] ? A_C1 : A_C0, rd_v, rsp);
         chk(rd_v, rows[i][7:0]);
      end
      $display("row test done");
      ev(9'h098);
      wr(A_C0, 8'hB5, rsp);
      rd(A_C0, rd_v, rsp);
      chk(rd_v, 8'hCA);
      wr(A_C0, 8'hB5, rsp);
      rd(A_C0, rd_v, rsp);
      chk(rd_v, 8'h85);
      chk(ep0_cnt, 8'h85);
      wr(A_AD, 8'h80, rsp);
      chk({addr_en, dev_addr}, 8'h80);
      wr(A_M1, 8'h8B, rsp);
      sie_tok <= usbep_pkg::TK_OUT;
      @(negedge mclk);
      chk(ep1_resp, usbep_pkg::RS_STALL);
      @(posedge mclk) sie_tok <= usbep_pkg::TK_IN;
      @(negedge mclk);
      chk(ep1_resp, usbep_pkg::RS_NAK);
      wr(A_M1, 8'h8F, rsp);
      chk(ep1_resp, usbep_pkg::RS_STALL);
      wr(A_M1, 8'h0B, rsp);
      ev(9'h101);
      rd(A_M1, rd_v, rsp);
      chk(rd_v, 8'h11);
      wr(A_AD, 8'h00, rsp);
      chk(ep1_resp, usbep_pkg::RS_IGN);
      $display("endpoint test done");
      wr(A_CT, 8'h08, rsp);
      chk(pullup_regulator_output_oe, 8'h01);
      suspend <= 1'b1;
      @(negedge mclk);
      chk({pullup_regulator_output_oe, pullup_regulator_output_weak_pu}, 8'h01);
      @(posedge mclk) suspend <= 1'b0;
      wr(A_CT, 8'h00, rsp);
      wr(A_AD, 8'h80, rsp);
      chk(pullup_regulator_output_oe, 8'h01);
      sie_tx <= 1'b1;
      @(negedge mclk);
      chk(pullup_regulator_output_oe, 8'h00);
      @(posedge mclk) sie_tx <= 1'b0;
      wr(A_AD, 8'h00, rsp);
      $display("regulator test done");
      wr(A_CT, 8'h87, rsp);
      chk(ps2_pu_en, 8'h01);
      hold_low <= 1'b1;
      for (i = 0; i < 3000 && ps2_irq !== 1'b1; i++) @(negedge mclk);
      chk(i > 2500 && i < 2700, 8'h01);
      @(posedge mclk) hold_low <= 1'b0;
      wr(A_CT, 8'h85, rsp);
      chk({dp_oe, dm_oe, dm_o}, 8'h02);
      rd(A_P2, rd_v, rsp);
      chk(rd_v, 8'h21);
      wr(8'hFC, 8'h00, rsp);
      chk(rsp, usbep_pkg::RESP_ERR);
      rd(8'hFC, rd_v, rsp);
      chk(rsp, usbep_pkg::RESP_ERR);
      $display("pin test done");
      stop_test();
   end
endmodule
